//--- logic/hprc_defines.vh
// Constants for the hybrid PLL ratio and mode control block.
// Assumes inclusion by bare name; definitions only.
`ifndef HPRC_DEFINES_VH
`define HPRC_DEFINES_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define HPRC_OFS_CTRL 8'h00
`define HPRC_OFS_SEL 8'h04
`define HPRC_OFS_STAT 8'h08
`define HPRC_OFS_SLOT0 8'h10
`define HPRC_OFS_EFF 8'h20
`define HPRC_OFS_ID 8'h24

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define HPRC_CTRL_EN1 0
`define HPRC_CTRL_EN2 1
`define HPRC_CTRL_MODESEL 2
`define HPRC_CTRL_FMT 3
`define HPRC_CTRL_ARC 4
`define HPRC_CTRL_MOD_LO 8
`define HPRC_CTRL_MOD_HI 10

// ------------------------------------------------------------
// Selector register fields
// ------------------------------------------------------------
`define HPRC_SEL_S_LO 0
`define HPRC_SEL_S_HI 1
`define HPRC_SEL_M_LO 4
`define HPRC_SEL_M_HI 5

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define HPRC_ST_UNLOCK 0
`define HPRC_ST_UNLOCK_LATCH 1
`define HPRC_ST_BADSET 2
`define HPRC_ST_BADLIVE 3
`define HPRC_ST_SYNTH 4
`define HPRC_ST_MULT 5
`define HPRC_ST_SMART 6
`define HPRC_ST_OUTEN 7

// ------------------------------------------------------------
// Modifier codes
// ------------------------------------------------------------
`define HPRC_MOD_NONE 3'h0
`define HPRC_MOD_X2 3'h1
`define HPRC_MOD_X4 3'h2
`define HPRC_MOD_X8 3'h3
`define HPRC_MOD_D2 3'h4
`define HPRC_MOD_D4 3'h5
`define HPRC_MOD_D8 3'h6
`define HPRC_MOD_D16 3'h7

// ------------------------------------------------------------
// Ratio geometry: internal 20.20 carrier
// ------------------------------------------------------------
`define HPRC_INT_MAX 20'hFFFFF
`define HPRC_ID_VALUE 32'h0000A5C3

`endif

//--- logic/hprc_ratio_ctrl.v
// Hybrid PLL ratio and mode control: enable, lock flags, ratio slots,
// modifier, truncation, invalid-ratio error and mode selection.
// Assumes an AHB-Lite master on clk_sys and asynchronous status pins.
//
// Function
// - Loop runs only while both enable bits set, any write order.
// - Live unlock flag high whenever not locked, including when disabled.
// - Latched unlock sets with live flag; write-one clear blocked while live.
// - Synthesizer mode: output equals timing reference times selected ratio.
// - Multiplier mode: output equals frequency reference times ratio, dynamic.
// - Four 32-bit slots; synth and multiplier selectors pick active slot.
// - Multiplier chooses 12.20 or 20.12; synthesizer always uses 12.20.
// - High-resolution format: upper 12 bits integer, lower 20 fraction.
// - High-multiplication format: upper 20 bits integer, lower 12 fraction.
// - Modifier multiplies by 2, 4, 8 or divides by 2, 4, 8, 16.
// - Effective ratio truncated to maximum multiplication and finest resolution.
// - Invalid ratio disables outputs; resumes once ratio becomes valid.
// - Latched invalid-ratio error; write-one clear blocked while still invalid.
// - Auto rate control in multiplier mode replaces slots and modifier.
// - Equal selectors: mode select field picks synthesizer or multiplier.
// - Different selectors: smart mode picks automatically from reference status.
// - Smart, zero synth ratio: no output until reference, then multiplier forever.
// - Smart, nonzero synth ratio: synth first, glitchless to multiplier forever.
// - Synthesizer drives loop with static ratio straight from control fields.
// - Synthesizer ratio relates to undivided reference; divider ignored.
// - Smart mode freezes dynamic ratio while reference missing or unstable.
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hprc_defines.vh"

module hprc_ratio_ctrl (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Status from loop and reference detectors (asynchronous)
  input wire pinFreqLocked,
  input wire pinRefPresent,
  input wire pinRefStable,
  input wire [31:0] autoRatio,
  // To the analog loop
  output reg loopEnable,
  output reg [31:0] effRatio,
  output reg effFmtHiMult,
  output reg useMultiplier,
  output reg ratioFrozen,
  output reg clkOutEnable,
  output reg freqUnlock
);

  // ------------------------------------------------------------
  // Reset release and input synchronisers
  // ------------------------------------------------------------
  reg [1:0] rstSync;
  wire rstN;
  reg [2:0] syncA;
  reg [2:0] syncB;
  wire locked;
  wire refOk;
  wire refSeen;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
    end else begin
      syncA <= {pinRefStable, pinRefPresent, pinFreqLocked};
      syncB <= syncA;
    end
  end
  assign locked = syncB[0];
  assign refSeen = syncB[1];
  assign refOk = syncB[1] & syncB[2];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg en1;
  reg en2;
  reg modeSel;
  reg fmtHiMult;
  reg arcEn;
  reg [2:0] slotMod;
  reg [1:0] synthSel;
  reg [1:0] multSel;
  reg [31:0] multiplierSlot [0:3];
  reg freqLockLostLatched;
  reg badSettingError;

  // AHB address phase capture
  reg wrPend;
  reg rdPend;
  reg [7:0] addrQ;
  wire take;
  assign take = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      addrQ <= 8'h00;
    end else begin
      wrPend <= take & hwrite;
      rdPend <= take & ~hwrite;
      if (take) begin
        addrQ <= haddr[7:0];
      end
    end
  end

  function isSlot;
    input [7:0] a;
    begin
      isSlot = (a[7:4] == `HPRC_OFS_SLOT0 >> 4) && (a[1:0] == 2'h0);
    end
  endfunction

  wire wrCtrl = wrPend & (addrQ == `HPRC_OFS_CTRL);
  wire wrSel = wrPend & (addrQ == `HPRC_OFS_SEL);
  wire wrStat = wrPend & (addrQ == `HPRC_OFS_STAT);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gSlot
      always @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
          multiplierSlot[gi] <= 32'h00000000;
        end else if (wrPend && isSlot(addrQ) && addrQ[3:2] == gi) begin
          multiplierSlot[gi] <= hwdata;
        end
      end
    end
  endgenerate

  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      en1 <= 1'b0;
      en2 <= 1'b0;
      modeSel <= 1'b0;
      fmtHiMult <= 1'b0;
      arcEn <= 1'b0;
      slotMod <= `HPRC_MOD_NONE;
      synthSel <= 2'h0;
      multSel <= 2'h0;
    end else begin
      if (wrCtrl) begin
        en1 <= hwdata[`HPRC_CTRL_EN1];
        en2 <= hwdata[`HPRC_CTRL_EN2];
        modeSel <= hwdata[`HPRC_CTRL_MODESEL];
        fmtHiMult <= hwdata[`HPRC_CTRL_FMT];
        arcEn <= hwdata[`HPRC_CTRL_ARC];
        slotMod <= hwdata[`HPRC_CTRL_MOD_HI:`HPRC_CTRL_MOD_LO];
      end
      if (wrSel) begin
        synthSel <= hwdata[`HPRC_SEL_S_HI:`HPRC_SEL_S_LO];
        multSel <= hwdata[`HPRC_SEL_M_HI:`HPRC_SEL_M_LO];
      end
    end
  end

  // ------------------------------------------------------------
  // Mode selection
  // ------------------------------------------------------------
  localparam [3:0] SM_IDLE = 4'b0001;
  localparam [3:0] SM_WAIT = 4'b0010;
  localparam [3:0] SM_SYNTH = 4'b0100;
  localparam [3:0] SM_MULT = 4'b1000;
  reg [3:0] smState;
  reg [3:0] next_smState;
  wire smart = (synthSel != multSel);
  wire synthZero = (multiplierSlot[synthSel] == 32'h00000000);
  wire enBoth = en1 & en2;

  // Once the reference has been seen the state stays in SM_MULT until enBoth or smart drops,
  // so a later dropout leaves the loop in multiplier operation.
  always @* begin
    next_smState = smState;
    case (smState)
      SM_IDLE: begin
        if (enBoth && smart) begin
          if (refSeen) begin
            next_smState = SM_MULT;
          end else if (synthZero) begin
            next_smState = SM_WAIT;
          end else begin
            next_smState = SM_SYNTH;
          end
        end
      end
      SM_WAIT: begin
        if (refSeen) begin
          next_smState = SM_MULT;
        end
      end
      SM_SYNTH: begin
        if (refSeen) begin
          next_smState = SM_MULT;
        end
      end
      SM_MULT: begin
        next_smState = SM_MULT;
      end
      default: begin
        next_smState = SM_IDLE;
      end
    endcase
    if (!enBoth || !smart) begin
      next_smState = SM_IDLE;
    end
  end

  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      smState <= SM_IDLE;
    end else begin
      smState <= next_smState;
    end
  end

  wire multMode = smart ? (smState == SM_MULT) : modeSel;
  wire smartHold = smart & (smState == SM_WAIT);
  wire [1:0] activeSel = multMode ? multSel : synthSel;

  // ------------------------------------------------------------
  // Ratio path: carrier is 20 integer bits . 20 fraction bits
  // ------------------------------------------------------------
  reg [39:0] base;
  reg [43:0] scaled;
  reg [31:0] outRatio;
  reg over;
  reg badRatio;
  reg fmtOut;
  wire [31:0] raw = multiplierSlot[activeSel];
  wire useArc = arcEn & multMode;
  wire hiMult = multMode & fmtHiMult;

  always @* begin
    if (hiMult) begin
      base = {raw, 8'h00};
    end else begin
      base = {8'h00, raw};
    end
    case (slotMod)
      `HPRC_MOD_X2: scaled = {3'h0, base, 1'b0};
      `HPRC_MOD_X4: scaled = {2'h0, base, 2'h0};
      `HPRC_MOD_X8: scaled = {1'b0, base, 3'h0};
      `HPRC_MOD_D2: scaled = {5'h00, base[39:1]};
      `HPRC_MOD_D4: scaled = {6'h00, base[39:2]};
      `HPRC_MOD_D8: scaled = {7'h00, base[39:3]};
      `HPRC_MOD_D16: scaled = {8'h00, base[39:4]};
      default: scaled = {4'h0, base};
    endcase
    // Saturate at the top integer limit; fraction below the finest step is dropped
    over = (scaled[43:40] != 4'h0);
    badRatio = 1'b0;
    fmtOut = 1'b0;
    if (useArc) begin
      outRatio = autoRatio;
      fmtOut = 1'b1;
      badRatio = (autoRatio == 32'h00000000);
    end else if (over || scaled[39:32] != 8'h00) begin
      // Beyond 12.20 reach: hand over in 20.12, 12-bit fraction
      fmtOut = 1'b1;
      outRatio = over ? {`HPRC_INT_MAX, 12'hFFF} : scaled[39:8];
      badRatio = (outRatio == 32'h00000000);
    end else begin
      outRatio = scaled[31:0];
      badRatio = (outRatio == 32'h00000000);
    end
  end

  // Software ordering is not checked; updates land at once.
  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      loopEnable <= 1'b0;
      effRatio <= 32'h00000000;
      effFmtHiMult <= 1'b0;
      useMultiplier <= 1'b0;
      ratioFrozen <= 1'b0;
      clkOutEnable <= 1'b0;
      freqUnlock <= 1'b1;
    end else begin
      loopEnable <= enBoth;
      useMultiplier <= multMode;
      // Freeze holds the last multiplier ratio through a reference dropout
      ratioFrozen <= smart & multMode & ~refOk;
      if (!(smart && multMode && !refOk)) begin
        effRatio <= outRatio;
        effFmtHiMult <= fmtOut;
      end
      clkOutEnable <= enBoth & ~badRatio & ~smartHold;
      freqUnlock <= ~(enBoth & locked);
    end
  end

  // ------------------------------------------------------------
  // Latched flags: set wins over the write-one clear
  // ------------------------------------------------------------
  // SM_WAIT on a zero synth ratio is masked, but its SM_IDLE entry cycle still sets the latched error
  wire badLive = enBoth & badRatio & ~smartHold;
  wire unlockLive = ~(enBoth & locked);

  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      freqLockLostLatched <= 1'b1;
      badSettingError <= 1'b0;
    end else begin
      if (unlockLive) begin
        freqLockLostLatched <= 1'b1;
      end else if (wrStat && hwdata[`HPRC_ST_UNLOCK_LATCH]) begin
        freqLockLostLatched <= 1'b0;
      end
      if (badLive) begin
        badSettingError <= 1'b1;
      end else if (wrStat && hwdata[`HPRC_ST_BADSET]) begin
        badSettingError <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= 32'h00000000;
      if (haddr[7:0] == `HPRC_OFS_CTRL) begin
        hrdata[`HPRC_CTRL_EN1] <= en1;
        hrdata[`HPRC_CTRL_EN2] <= en2;
        hrdata[`HPRC_CTRL_MODESEL] <= modeSel;
        hrdata[`HPRC_CTRL_FMT] <= fmtHiMult;
        hrdata[`HPRC_CTRL_ARC] <= arcEn;
        hrdata[`HPRC_CTRL_MOD_HI:`HPRC_CTRL_MOD_LO] <= slotMod;
      end else if (haddr[7:0] == `HPRC_OFS_SEL) begin
        hrdata[`HPRC_SEL_S_HI:`HPRC_SEL_S_LO] <= synthSel;
        hrdata[`HPRC_SEL_M_HI:`HPRC_SEL_M_LO] <= multSel;
      end else if (haddr[7:0] == `HPRC_OFS_STAT) begin
        hrdata[`HPRC_ST_UNLOCK] <= freqUnlock;
        hrdata[`HPRC_ST_UNLOCK_LATCH] <= freqLockLostLatched;
        hrdata[`HPRC_ST_BADSET] <= badSettingError;
        hrdata[`HPRC_ST_BADLIVE] <= badLive;
        hrdata[`HPRC_ST_SYNTH] <= ~useMultiplier;
        hrdata[`HPRC_ST_MULT] <= useMultiplier;
        hrdata[`HPRC_ST_SMART] <= smart;
        hrdata[`HPRC_ST_OUTEN] <= clkOutEnable;
      end else if (isSlot(haddr[7:0])) begin
        hrdata <= multiplierSlot[haddr[3:2]];
      end else if (haddr[7:0] == `HPRC_OFS_EFF) begin
        hrdata <= effRatio;
      end else if (haddr[7:0] == `HPRC_OFS_ID) begin
        hrdata <= `HPRC_ID_VALUE; // Arbitrary identification value
      end
    end
  end

  wire unusedBits = rdPend | (|hsize) | (|haddr[31:8]);

endmodule
`default_nettype wire

//--- dv/hprc_ratio_ctrl_assertions.sv
// Port assertions for the hybrid PLL ratio and mode control block.
// Assumes one clock domain and binding onto hprc_ratio_ctrl.
`timescale 1ns/1ps
`default_nettype none

module hprc_ratio_ctrl_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins and loop side
  input wire logic pinFreqLocked,
  input wire logic pinRefPresent,
  input wire logic loopEnable,
  input wire logic [31:0] effRatio,
  input wire logic useMultiplier,
  input wire logic ratioFrozen,
  input wire logic clkOutEnable,
  input wire logic freqUnlock
);
  logic [2:0] wrAge;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ------------------------------------------------------------
  // Helper: cycles since the last write request
  // ------------------------------------------------------------
  // Register updates land a few edges after the request, so quiet means 4+
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      wrAge <= 3'h0;
    else if (hsel && htrans[1] && hwrite)
      wrAge <= 3'h0;
    else if (wrAge != 3'h7)
      wrAge <= wrAge + 3'h1;
  end

  sequence s_quiet;
    wrAge >= 3'h4;
  endsequence

  sequence s_locked;
    loopEnable && pinFreqLocked;
  endsequence

  sequence s_mult_lost;
    useMultiplier && !pinRefPresent;
  endsequence

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or response not okay");
  a_enable_steady: assert property (s_quiet |-> $stable(loopEnable))
    else $error("loop enable moved without a write");
  a_live_disabled: assert property ((!loopEnable) [*3] |-> freqUnlock)
    else $error("unlock low while loop disabled");
  a_live_locked: assert property (s_locked [*5] |-> !freqUnlock)
    else $error("unlock high while enabled and locked");
  a_live_unlocked: assert property ((!pinFreqLocked) [*5] |-> freqUnlock)
    else $error("unlock low while loop not locked");
  a_out_disabled: assert property ((!loopEnable) [*2] |-> !clkOutEnable)
    else $error("outputs on while loop disabled");
  a_out_bad_ratio: assert property ((effRatio == 32'h0) [*2] |-> !clkOutEnable)
    else $error("outputs on with zero ratio");
  a_freeze_hold: assert property (ratioFrozen [*2] |-> $stable(effRatio))
    else $error("ratio moved while frozen");
  a_freeze_mult: assert property (ratioFrozen |-> useMultiplier)
    else $error("frozen outside multiplier operation");
  a_smart_sticky: assert property (s_quiet ##0 s_mult_lost |=> useMultiplier)
    else $error("multiplier operation left after reference loss");
endmodule

bind hprc_ratio_ctrl hprc_ratio_ctrl_assertions u_assert (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .pinFreqLocked(pinFreqLocked),
  .pinRefPresent(pinRefPresent),
  .loopEnable(loopEnable),
  .effRatio(effRatio),
  .useMultiplier(useMultiplier),
  .ratioFrozen(ratioFrozen),
  .clkOutEnable(clkOutEnable),
  .freqUnlock(freqUnlock)
);
`default_nettype wire

//--- dv/hybrid_pll_ratio_mode_control_tb.sv
// Self-checking bench for the hybrid PLL ratio and mode control block.
// Assumes the design, its defines header and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "hprc_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module hybrid_pll_ratio_mode_control_tb;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic pinFreqLocked = 1'b0;
  logic pinRefPresent = 1'b0;
  logic pinRefStable = 1'b0;
  logic [31:0] autoRatio = 32'h0030_0000;
  logic [31:0] rdat;
  wire hreadyout, hresp, loopEnable, effFmtHiMult, useMultiplier, ratioFrozen;
  wire clkOutEnable, freqUnlock;
  wire [31:0] hrdata, effRatio;
  int miscompares = 0;
  int comparisons = 0;

  always #2 clk_sys = ~clk_sys;

  hprc_ratio_ctrl dut (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pinFreqLocked(pinFreqLocked), .pinRefPresent(pinRefPresent),
    .pinRefStable(pinRefStable), .autoRatio(autoRatio), .loopEnable(loopEnable),
    .effRatio(effRatio), .effFmtHiMult(effFmtHiMult), .useMultiplier(useMultiplier),
    .ratioFrozen(ratioFrozen), .clkOutEnable(clkOutEnable), .freqUnlock(freqUnlock)
  );

  // ------------------------------------------------------------
  // Bus and pin helpers
  // ------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rdat = hrdata;
  endtask

  // Outputs follow a write one edge after its data phase
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  // Status pins pass a two-stage synchroniser, so allow generous settling
  task automatic pins(input logic lk, input logic rf);
    @(posedge clk_sys);
    pinFreqLocked <= lk;
    pinRefPresent <= rf;
    pinRefStable <= rf;
    repeat (6) @(posedge clk_sys);
  endtask

  function automatic logic [31:0] cw(input logic ms, fm, ar, input logic [2:0] md);
    cw = {21'h0, md, 3'h0, ar, fm, ms, 2'h3};
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd(`HPRC_OFS_ID);
    `CHK(rdat, `HPRC_ID_VALUE)
    rd(8'h30);
    `CHK(rdat, 32'h0)
    rd(`HPRC_OFS_STAT);
    `CHK(rdat[1:0], 2'h3)
  endtask

  task automatic t_enable;
    logic [1:0] seq [6] = '{2'h1, 2'h3, 2'h2, 2'h3, 2'h0, 2'h3};
    foreach (seq[i]) begin
      wr(`HPRC_OFS_CTRL, {30'h0, seq[i]});
      `CHK(loopEnable, &seq[i])
    end
  endtask

  task automatic t_unlock;
    pins(1'b1, 1'b0);
    `CHK(freqUnlock, 1'b0)
    wr(`HPRC_OFS_STAT, 32'h2);
    rd(`HPRC_OFS_STAT);
    `CHK(rdat[1], 1'b0)
    pins(1'b0, 1'b0);
    wr(`HPRC_OFS_STAT, 32'h2);
    rd(`HPRC_OFS_STAT);
    `CHK(rdat[1:0], 2'h3)
    pins(1'b1, 1'b0);
    wr(`HPRC_OFS_CTRL, 32'h1);
    `CHK(freqUnlock, 1'b1)
  endtask

  task automatic t_mod;
    logic [31:0] expv;
    wr(`HPRC_OFS_SLOT0, 32'h0010_0000);
    wr(`HPRC_OFS_SEL, 32'h0);
    for (int m = 0; m < 8; m++) begin
      expv = (m < 4) ? (32'h0010_0000 << m) : (32'h0010_0000 >> (m - 3));
      wr(`HPRC_OFS_CTRL, cw(1'b0, m[0], 1'b0, m[2:0]));
      `CHK(effRatio, expv)
      `CHK(effFmtHiMult, 1'b0)
      `CHK(useMultiplier, 1'b0)
      `CHK(clkOutEnable, 1'b1)
    end
  endtask

  task automatic t_trunc;
    wr(`HPRC_OFS_SLOT0, 32'h8000_0000);
    wr(`HPRC_OFS_CTRL, cw(1'b0, 1'b0, 1'b0, 3'h3));
    `CHK(effRatio, 32'h0400_0000)
    `CHK(effFmtHiMult, 1'b1)
    wr(`HPRC_OFS_SLOT0, 32'h0000_0001);
    wr(`HPRC_OFS_CTRL, cw(1'b0, 1'b0, 1'b0, 3'h7));
    `CHK(effRatio, 32'h0)
    `CHK(clkOutEnable, 1'b0)
    wr(`HPRC_OFS_STAT, 32'h4);
    rd(`HPRC_OFS_STAT);
    `CHK(rdat[2], 1'b1)
    wr(`HPRC_OFS_CTRL, cw(1'b0, 1'b0, 1'b0, 3'h0));
    `CHK(clkOutEnable, 1'b1)
    wr(`HPRC_OFS_STAT, 32'h4);
    rd(`HPRC_OFS_STAT);
    `CHK(rdat[2], 1'b0)
  endtask

  task automatic t_mult;
    wr(`HPRC_OFS_CTRL, cw(1'b1, 1'b1, 1'b0, 3'h0));
    for (int i = 0; i < 4; i++) begin
      wr(`HPRC_OFS_SLOT0 + 8'(4 * i), 32'(i + 1) << 24);
      wr(`HPRC_OFS_SEL, {26'h0, i[1:0], 2'h0, i[1:0]});
      `CHK(effRatio, 32'(i + 1) << 24)
      `CHK(useMultiplier, 1'b1)
      `CHK(effFmtHiMult, 1'b1)
    end
    wr(`HPRC_OFS_SLOT0 + 8'hC, 32'hFFFF_F000);
    wr(`HPRC_OFS_CTRL, cw(1'b1, 1'b1, 1'b0, 3'h1));
    `CHK(effRatio, 32'hFFFF_FFFF)
    wr(`HPRC_OFS_CTRL, cw(1'b1, 1'b1, 1'b1, 3'h1));
    `CHK(effRatio, autoRatio)
    `CHK(effFmtHiMult, 1'b1)
  endtask

  task automatic t_smart;
    wr(`HPRC_OFS_CTRL, 32'h0);
    wr(`HPRC_OFS_SLOT0, 32'h0);
    wr(`HPRC_OFS_SLOT0 + 8'h4, 32'h0020_0000);
    wr(`HPRC_OFS_SEL, 32'h10);
    wr(`HPRC_OFS_CTRL, cw(1'b0, 1'b0, 1'b0, 3'h0));
    `CHK(clkOutEnable, 1'b0)
    pins(1'b1, 1'b1);
    `CHK(useMultiplier, 1'b1)
    `CHK(clkOutEnable, 1'b1)
    `CHK(effRatio, 32'h0020_0000)
    pins(1'b1, 1'b0);
    `CHK(useMultiplier, 1'b1)
    `CHK(ratioFrozen, 1'b1)
    wr(`HPRC_OFS_SLOT0 + 8'h4, 32'h0030_0000);
    `CHK(effRatio, 32'h0020_0000)
    wr(`HPRC_OFS_CTRL, 32'h0);
    wr(`HPRC_OFS_SLOT0, 32'h0010_0000);
    wr(`HPRC_OFS_CTRL, cw(1'b0, 1'b0, 1'b0, 3'h0));
    `CHK(useMultiplier, 1'b0)
    `CHK(effRatio, 32'h0010_0000)
    `CHK(clkOutEnable, 1'b1)
    pins(1'b1, 1'b1);
    `CHK(useMultiplier, 1'b1)
  endtask

  // ------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ------------------------------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_regs;
    t_enable;
    t_unlock;
    t_mod;
    t_trunc;
    t_mult;
    t_smart;
    results;
  end

  // The full sequence needs well under 3000 cycles
  initial begin
    #60000;
    miscompares++;
    results;
  end
endmodule
`default_nettype wire
